// ---- src/csq_sequencer.sv ----
// conversion sequencer with oversampling filter, offset codes, low power
// wake pacing and an APB register slave
// assumes an analog modulator returning one bit per sampling tick
//
// Notes on behaviour
// - 250 kHz sampling, 16-bit results, 13 inputs
// - oversampling select in control bits 9:8
// - select 00=256, 01=128, 10/11=64
// - average three times the ratio samples
// - sequence time is stages times stage time
// - per-stage 6-bit positive and negative offsets
// - start at stage 0, stop at last-stage
// - at most 12 stages, each own settings
// - differential pair: one active, both gives none
// - wake delay 200/400/600/800 ms by code
// - low power: one sequence then delay
// - power mode 00 full, 10 low, else off
// - each stage result stored in own register
`timescale 1ns/1ps
`include "csq_regs.svh"

module csq_sequencer import csq_pkg::*; #(
	parameter int WAKE_STEP_TICKS = `CSQ_LP_STEP_MS * `CSQ_MOD_RATE_KHZ
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        mod_bit,
	output logic             mod_tick,
	output logic             afe_enable,
	output logic      [3:0]  active_stage,
	output logic      [27:0] stage_input_mux_setup,
	output logic      [5:0]  positive_offset_code,
	output logic      [5:0]  negative_offset_code,
	output logic      [15:0] stage_calibration_enable,
	output logic             result_valid
);

	localparam int TICK_DIV = `CSQ_SYS_CLK_KHZ / `CSQ_MOD_RATE_KHZ;

	csq_state_t  state;
	logic [15:0] ctrl;
	logic [15:0] margin;
	logic [15:0] ofs_mem [`CSQ_NSTAGES];
	logic [27:0] mux_mem [`CSQ_NSTAGES];
	logic [15:0] res_mem [`CSQ_NSTAGES];
	logic [11:0] btn_pos;
	logic [11:0] btn_neg;
	logic [3:0]  cur_stage;
	logic [3:0]  last_lat;
	logic [9:0]  osr_lat;
	logic [9:0]  samp_total;
	logic [9:0]  scount;
	logic [9:0]  ones;
	logic [24:0] recip;
	logic [35:0] prod;
	logic [15:0] next_result;
	logic [19:0] wait_cnt;
	logic [19:0] wait_tgt;
	logic [15:0] seq_count;
	logic [15:0] cur_ofs;
	logic        tick;
	logic        mod_meta;
	logic        mod_sync;
	logic [1:0]  pmode;
	logic        seq_end;
	logic        acc_wr;
	logic        acc_rd;
	logic        bad_acc;
	csq_region_t rg;
	logic [3:0]  rg_stage;
	logic [31:0] next_rdata;
	logic [15:0] stage_cal_en;

	function automatic csq_region_t csq_decode(input logic [11:0] a);
		logic [9:0] idx;
		idx = a[11:2];
		csq_decode = CSQ_RG_NONE;
		if (a[1:0] == 2'h0) begin
			if (idx == `CSQ_CTRL_IDX)
				csq_decode = CSQ_RG_CTRL;
			else if (idx == `CSQ_CALEN_IDX)
				csq_decode = CSQ_RG_CALEN;
			else if (idx == `CSQ_STAT_IDX)
				csq_decode = CSQ_RG_STAT;
			else if (idx == `CSQ_MARGIN_IDX)
				csq_decode = CSQ_RG_MARGIN;
			else if (idx == `CSQ_BTN_IDX)
				csq_decode = CSQ_RG_BTN;
			else if (idx >= `CSQ_RES_BASE &&
				idx < `CSQ_RES_BASE + 10'(`CSQ_NSTAGES))
				csq_decode = CSQ_RG_RES;
			else if (idx >= `CSQ_OFS_BASE &&
				idx < `CSQ_OFS_BASE + 10'(`CSQ_NSTAGES))
				csq_decode = CSQ_RG_OFS;
			else if (idx >= `CSQ_MUX_BASE &&
				idx < `CSQ_MUX_BASE + 10'(`CSQ_NSTAGES))
				csq_decode = CSQ_RG_MUX;
		end
	endfunction : csq_decode

	function automatic logic [3:0] csq_stage_of(input logic [11:0] a);
		logic [9:0] idx;
		idx = a[11:2];
		if (idx >= `CSQ_MUX_BASE)
			csq_stage_of = 4'(idx - `CSQ_MUX_BASE);
		else if (idx >= `CSQ_OFS_BASE)
			csq_stage_of = 4'(idx - `CSQ_OFS_BASE);
		else
			csq_stage_of = 4'(idx - `CSQ_RES_BASE);
	endfunction : csq_stage_of

	function automatic logic [9:0] csq_osr(input logic [1:0] code);
		case (code)
		2'h0:    csq_osr = `CSQ_OSR_HI;
		2'h1:    csq_osr = `CSQ_OSR_MID;
		default: csq_osr = `CSQ_OSR_LO;
		endcase
	endfunction : csq_osr

	// modulator bit comes from the analog side
	always_ff @(posedge sys_clk) begin
		mod_meta <= mod_bit;
		mod_sync <= mod_meta;
	end

	csq_tick_div #(
		.DIV (TICK_DIV)
	) u_tick (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.run     (state == CSQ_CONV || state == CSQ_WAIT),
		.tick    (tick)
	);

	assign pmode = ctrl[`CSQ_PMODE_LSB +: 2];
	assign seq_end = (cur_stage == last_lat);
	assign samp_total = 10'(`CSQ_SAMPLES_PER_OSR * osr_lat);
	assign recip = 25'((64'(`CSQ_FULL_SCALE) << 16) / 64'(samp_total));
	assign prod = 36'(ones) * 36'(recip);
	assign next_result = (|prod[35:32]) ? `CSQ_FULL_SCALE : prod[31:16];
	assign cur_ofs = ofs_mem[cur_stage];

	// sequencer; shutdown aborts at once, any other mode runs
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= CSQ_IDLE;
			cur_stage <= 4'h0;
			last_lat <= 4'h0;
			osr_lat <= `CSQ_OSR_HI;
		end else if (pmode != `CSQ_PM_FULL && pmode != `CSQ_PM_LOW) begin
			state <= CSQ_IDLE;
		end else begin
			case (state)
			CSQ_IDLE: begin
				state <= CSQ_START;
			end
			CSQ_START: begin
				// ratio and last stage only sampled here, never mid-sequence
				osr_lat <= csq_osr(ctrl[`CSQ_OSR_LSB +: 2]);
				last_lat <= (ctrl[`CSQ_LAST_LSB +: 4] > `CSQ_LAST_MAX) ?
					`CSQ_LAST_MAX : ctrl[`CSQ_LAST_LSB +: 4];
				cur_stage <= 4'h0;
				state <= CSQ_CONV;
			end
			CSQ_CONV: begin
				if (scount == samp_total)
					state <= CSQ_STORE;
			end
			CSQ_STORE: begin
				if (!seq_end) begin
					cur_stage <= cur_stage + 4'h1;
					state <= CSQ_CONV;
				end else if (pmode == `CSQ_PM_LOW) begin
					state <= CSQ_WAIT;
				end else begin
					state <= CSQ_START;
				end
			end
			CSQ_WAIT: begin
				if (pmode == `CSQ_PM_FULL || wait_cnt >= wait_tgt)
					state <= CSQ_START;
			end
			default: state <= CSQ_IDLE;
			endcase
		end
	end

	// averaging filter: count ones over the stage window
	always_ff @(posedge sys_clk) begin
		if (!rst_n || state != CSQ_CONV) begin
			scount <= 10'h000;
			ones <= 10'h000;
		end else if (tick && scount != samp_total) begin
			scount <= scount + 10'h001;
			ones <= ones + 10'(mod_sync);
		end
	end

	// wake-up pacing measured in sampling ticks
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wait_cnt <= 20'h00000;
			wait_tgt <= 20'h00000;
		end else if (state == CSQ_STORE && seq_end) begin
			wait_cnt <= 20'h00000;
			wait_tgt <= 20'((32'(ctrl[`CSQ_WAKE_LSB +: 2]) + 32'h1) *
				WAKE_STEP_TICKS);
		end else if (state == CSQ_WAIT && tick) begin
			wait_cnt <= wait_cnt + 20'h00001;
		end
	end

	// results and completed-sequence count
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `CSQ_NSTAGES; i++)
				res_mem[i] <= 16'h0000;
			seq_count <= 16'h0000;
			result_valid <= 1'b0;
		end else begin
			result_valid <= (state == CSQ_STORE);
			if (state == CSQ_STORE) begin
				res_mem[cur_stage] <= next_result;
				if (seq_end)
					seq_count <= seq_count + 16'h0001;
			end
		end
	end

	// per-stage settings driven out during conversion
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			stage_input_mux_setup <= 28'h0000000;
			positive_offset_code <= 6'h00;
			negative_offset_code <= 6'h00;
			active_stage <= 4'h0;
			afe_enable <= 1'b0;
			mod_tick <= 1'b0;
		end else begin
			stage_input_mux_setup <= mux_mem[cur_stage];
			positive_offset_code <= cur_ofs[`CSQ_POS_OFS_LSB +: 6];
			negative_offset_code <= cur_ofs[`CSQ_NEG_OFS_LSB +: 6];
			active_stage <= cur_stage;
			afe_enable <= (state == CSQ_START || state == CSQ_CONV ||
				state == CSQ_STORE);
			mod_tick <= tick && (state == CSQ_CONV);
		end
	end

	// differential pair: a touch on both sides cancels to midscale
	generate
		for (genvar s = 0; s < `CSQ_NSTAGES; s++) begin : g_btn
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					btn_pos[s] <= 1'b0;
					btn_neg[s] <= 1'b0;
				end else begin
					btn_pos[s] <= 17'(res_mem[s]) >
						17'(`CSQ_MIDSCALE) + 17'(margin);
					btn_neg[s] <= 17'(res_mem[s]) + 17'(margin) <
						17'(`CSQ_MIDSCALE);
				end
			end
		end
	endgenerate

	// APB slave, zero wait states
	assign rg = csq_decode(paddr);
	assign rg_stage = csq_stage_of(paddr);
	assign acc_wr = psel && penable && pwrite;
	assign acc_rd = psel && !penable && !pwrite;
	assign bad_acc = (rg == CSQ_RG_NONE) || (pwrite && (rg == CSQ_RG_STAT ||
		rg == CSQ_RG_BTN || rg == CSQ_RG_RES));
	assign pready = 1'b1;
	assign pslverr = psel && penable && bad_acc;
	assign stage_calibration_enable = stage_cal_en;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl <= `CSQ_CTRL_RST;
			stage_cal_en <= 16'h0000;
			margin <= `CSQ_MARGIN_RST;
			for (int i = 0; i < `CSQ_NSTAGES; i++) begin
				ofs_mem[i] <= 16'h0000;
				mux_mem[i] <= 28'h0000000;
			end
		end else if (acc_wr && !bad_acc) begin
			case (rg)
			CSQ_RG_CTRL:   ctrl <= pwdata[15:0];
			CSQ_RG_CALEN:  stage_cal_en <= pwdata[15:0];
			CSQ_RG_MARGIN: margin <= pwdata[15:0];
			CSQ_RG_OFS:    ofs_mem[rg_stage] <= pwdata[15:0] & `CSQ_OFS_MASK;
			CSQ_RG_MUX:    mux_mem[rg_stage] <= pwdata[27:0];
			default:       ;
			endcase
		end
	end

	always_comb begin
		next_rdata = 32'h00000000;
		case (rg)
		CSQ_RG_CTRL:   next_rdata = {16'h0000, ctrl};
		CSQ_RG_CALEN:  next_rdata = {16'h0000, stage_cal_en};
		CSQ_RG_MARGIN: next_rdata = {16'h0000, margin};
		CSQ_RG_RES:    next_rdata = {16'h0000, res_mem[rg_stage]};
		CSQ_RG_OFS:    next_rdata = {16'h0000, ofs_mem[rg_stage]};
		CSQ_RG_MUX:    next_rdata = {4'h0, mux_mem[rg_stage]};
		CSQ_RG_BTN: begin
			next_rdata[11:0] = btn_pos;
			next_rdata[`CSQ_BTN_NEG_LSB +: 12] = btn_neg;
		end
		CSQ_RG_STAT: begin
			next_rdata[0] = afe_enable;
			next_rdata[`CSQ_STAT_STG_LSB +: 4] = cur_stage;
			next_rdata[`CSQ_STAT_WT_BIT] = (state == CSQ_WAIT);
			next_rdata[`CSQ_STAT_CNT_LSB +: 16] = seq_count;
		end
		default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			prdata <= 32'h00000000;
		else if (acc_rd)
			prdata <= next_rdata;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	osr_map_a: assert property (state == CSQ_START &&
		pmode == `CSQ_PM_FULL && ctrl[`CSQ_OSR_LSB +: 2] == 2'h1 |=>
		osr_lat == `CSQ_OSR_MID)
		else $error("ratio select 01 did not give 128");
	stage_len_a: assert property (state == CSQ_STORE |->
		scount == 10'(`CSQ_SAMPLES_PER_OSR * osr_lat))
		else $error("stage ended with wrong sample count");
	seq_begin_a: assert property (state == CSQ_START && pmode ==
		`CSQ_PM_FULL |=> cur_stage == 4'h0 && state == CSQ_CONV)
		else $error("sequence did not begin at stage zero");
	last_clamp_a: assert property (last_lat <= `CSQ_LAST_MAX)
		else $error("more than twelve stages in a sequence");
	result_store_a: assert property (state == CSQ_STORE && pmode ==
		`CSQ_PM_FULL |=> res_mem[$past(cur_stage)] == $past(next_result))
		else $error("stage result not stored in its register");
	fp_restart_a: assert property (state == CSQ_STORE && seq_end &&
		pmode == `CSQ_PM_FULL |=> state == CSQ_START ##1 cur_stage == 4'h0)
		else $error("full power did not restart the sequence");
	lp_wait_a: assert property (state == CSQ_STORE && seq_end &&
		pmode == `CSQ_PM_LOW |=> state == CSQ_WAIT)
		else $error("low power sequence did not go to wait");
	wake_delay_a: assert property (state == CSQ_WAIT &&
		$past(state) == CSQ_STORE |-> wait_tgt == 20'((32'(
		ctrl[`CSQ_WAKE_LSB +: 2]) + 32'h1) * WAKE_STEP_TICKS))
		else $error("wake delay target wrong");
	// afe_enable is registered from state, so it drops one cycle later
	shutdown_a: assert property (pmode == 2'h1 || pmode == 2'h3 |=>
		state == CSQ_IDLE ##1 !afe_enable)
		else $error("shutdown code did not stop conversion");
	button_excl_a: assert property ((btn_pos & btn_neg) == 12'h000)
		else $error("both sides of a pair reported active");
	osr_hold_a: assert property (state != CSQ_START |=>
		$stable(osr_lat) && $stable(last_lat))
		else $error("settings changed inside a sequence");
	ofs_out_a: assert property (state == CSQ_CONV &&
		$past(state) == CSQ_CONV |-> positive_offset_code ==
		$past(cur_ofs[`CSQ_POS_OFS_LSB +: 6]))
		else $error("positive offset code not that of the stage");

endmodule : csq_sequencer

// ---- common/csq_regs.svh ----
// register indices, field positions, reset values and timing for the
// capacitance conversion sequencer; definitions only
`ifndef CSQ_REGS_SVH
`define CSQ_REGS_SVH

// register indices; byte address is four times the index
`define CSQ_CTRL_IDX     10'h000
`define CSQ_CALEN_IDX    10'h001
`define CSQ_STAT_IDX     10'h008
`define CSQ_MARGIN_IDX   10'h009
`define CSQ_BTN_IDX      10'h00A
`define CSQ_RES_BASE     10'h00B
`define CSQ_OFS_BASE     10'h070
`define CSQ_MUX_BASE     10'h080

// power_and_conversion_control fields
`define CSQ_PMODE_LSB    0
`define CSQ_WAKE_LSB     2
`define CSQ_LAST_LSB     4
`define CSQ_OSR_LSB      8
`define CSQ_CTRL_RST     16'h0000

// stage_front_end_offset fields
`define CSQ_POS_OFS_LSB  8
`define CSQ_NEG_OFS_LSB  0
`define CSQ_OFS_MASK     16'h3F3F

// status and button fields
`define CSQ_STAT_STG_LSB 4
`define CSQ_STAT_WT_BIT  8
`define CSQ_STAT_CNT_LSB 16
`define CSQ_BTN_NEG_LSB  16

`define CSQ_NSTAGES      12
`define CSQ_LAST_MAX     4'hB
`define CSQ_PM_FULL      2'h0
`define CSQ_PM_LOW       2'h2

// oversampling ratios and filter length
`define CSQ_OSR_HI       10'h100
`define CSQ_OSR_MID      10'h080
`define CSQ_OSR_LO       10'h040
`define CSQ_SAMPLES_PER_OSR 3

`define CSQ_FULL_SCALE   16'hFFFF
`define CSQ_MIDSCALE     16'h8000
`define CSQ_MARGIN_RST   16'h0400

// timing
`define CSQ_SYS_CLK_KHZ  40000
`define CSQ_MOD_RATE_KHZ 250
`define CSQ_LP_STEP_MS   200

`endif

// ---- common/csq_pkg.sv ----
// types shared by the conversion sequencer files
// assumes csq_regs.svh supplies the numbers
package csq_pkg;

	typedef enum {
		CSQ_IDLE,
		CSQ_START,
		CSQ_CONV,
		CSQ_STORE,
		CSQ_WAIT
	} csq_state_t;

	typedef enum {
		CSQ_RG_NONE,
		CSQ_RG_CTRL,
		CSQ_RG_CALEN,
		CSQ_RG_STAT,
		CSQ_RG_MARGIN,
		CSQ_RG_BTN,
		CSQ_RG_RES,
		CSQ_RG_OFS,
		CSQ_RG_MUX
	} csq_region_t;

endpackage : csq_pkg

// ---- src/csq_tick_div.sv ----
// divider making the one-cycle modulator sampling enable
// assumes one system clock; run low holds the phase at zero
`timescale 1ns/1ps
`include "csq_regs.svh"

module csq_tick_div import csq_pkg::*; #(
	parameter int DIV = 160
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      tick
);

	logic [15:0] cnt;

	always_ff @(posedge sys_clk) begin
		if (!rst_n || !run) begin
			cnt <= 16'h0000;
		end else if (cnt == 16'(DIV - 1)) begin
			cnt <= 16'h0000;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end

	assign tick = run && (cnt == 16'(DIV - 1));

	tick_period_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n) tick && run |=> !tick [*8])
		else $error("modulator tick repeated too soon");

endmodule : csq_tick_div

// ---- bench/csq_mod_model.sv ----
// modulator stand-in answering the sequencer's sampling ticks
// assumes the bench picks the bit level that the sensor would give
`timescale 1ns/1ps

module csq_mod_model import csq_pkg::*; (
	input  wire logic sys_clk,
	input  wire logic mod_tick,
	input  wire logic afe_enable,
	input  wire logic ones,
	output logic      mod_bit
);
	// settles while idle, so no stale level leaks into a new sequence
	always_ff @(posedge sys_clk) begin
		if (mod_tick || !afe_enable)
			mod_bit <= ones;
	end
endmodule : csq_mod_model

// ---- bench/tb.sv ----
// self-checking bench for the conversion sequencer
// assumes the modulator model and a 40 MHz system clock
`timescale 1ns/1ps
`include "csq_regs.svh"

module tb import csq_pkg::*;;
	logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        mod_bit, mod_tick, afe_enable, result_valid, ones;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [3:0]  active_stage;
	logic [5:0]  pos_code, neg_code;
	logic [15:0] cal_en;
	logic [27:0] mux_out;
	logic [33:0] expq[$];
	int          mismatches, checks, cyc, tks, w;

	csq_sequencer #(.WAKE_STEP_TICKS(20)) csq_sequencer_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mod_bit(mod_bit), .mod_tick(mod_tick),
		.afe_enable(afe_enable), .active_stage(active_stage),
		.stage_input_mux_setup(mux_out), .positive_offset_code(pos_code),
		.negative_offset_code(neg_code),
		.stage_calibration_enable(cal_en), .result_valid(result_valid)
	);

	csq_mod_model csq_mod_model_inst (
		.sys_clk(sys_clk), .mod_tick(mod_tick),
		.afe_enable(afe_enable), .ones(ones), .mod_bit(mod_bit)
	);

	function automatic logic [11:0] ba(input logic [9:0] i);
		return {i, 2'b00};
	endfunction : ba

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	// one transfer; the note is taken off the queue by the monitor
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] dat, input logic err, input logic [31:0] ed);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		expq.push_back({~wr, err, ed});
		@(posedge sys_clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge sys_clk);
			if (pready === 1'b1)
				break;
		end
		if (n == 16) begin
			mismatches++;
			$display("MISMATCH pready expected 1 seen timeout");
			test_done();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// want_rv picks result_valid, else afe_enable; counts clocks and ticks
	task automatic run_to(input bit want_rv, input int lim);
		bit hit;
		hit = 0;
		cyc = 0;
		tks = 0;
		while (!hit && cyc < lim) begin
			@(posedge sys_clk);
			cyc++;
			if (mod_tick === 1'b1)
				tks++;
			hit = want_rv ? result_valid === 1'b1 : afe_enable === 1'b1;
		end
		if (!hit) begin
			mismatches++;
			$display("MISMATCH wait expected event seen timeout");
			test_done();
		end
	endtask : run_to

	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
			if (expq[0][33])
				chk("prdata", expq[0][31:0], prdata);
			chk("pslverr", {31'h0, expq[0][32]}, {31'h0, pslverr});
			void'(expq.pop_front());
		end
	end

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ones = 1'b1;
		mismatches = 0;
		checks = 0;
		void'($urandom(76));
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		apb(0, ba(`CSQ_CTRL_IDX), 0, 0, 32'h0);
		apb(1, ba(`CSQ_CTRL_IDX), 32'h1, 0, 0);
		repeat (3) @(posedge sys_clk);
		chk("afe_enable", 0, {31'h0, afe_enable});
		apb(0, ba(`CSQ_MARGIN_IDX), 0, 0, 32'h0400);
		apb(0, 12'h0FC, 0, 1, 0);
		apb(0, 12'h002, 0, 1, 0);
		apb(1, ba(`CSQ_RES_BASE), 32'h1234, 1, 0);
		d = $urandom;
		apb(1, ba(`CSQ_OFS_BASE), d, 0, 0);
		apb(0, ba(`CSQ_OFS_BASE), 0, 0, d & 32'h3F3F);
		apb(1, ba(`CSQ_CALEN_IDX), d, 0, 0);
		apb(0, ba(`CSQ_CALEN_IDX), 0, 0, {16'h0, d[15:0]});
		@(posedge sys_clk);
		chk("cal_en", {16'h0, d[15:0]}, {16'h0, cal_en});
		apb(1, ba(`CSQ_MUX_BASE), d, 0, 0);
		apb(0, ba(`CSQ_MUX_BASE), 0, 0, {4'h0, d[27:0]});
		$display("test registers done");
		// code 01 is only started: the ratio latch is asserted on
		apb(1, ba(`CSQ_CTRL_IDX), 32'h100, 0, 0);
		run_to(0, 20);
		apb(1, ba(`CSQ_CTRL_IDX), 32'h1, 0, 0);
		repeat (3) @(posedge sys_clk);
		chk("afe_enable", 0, {31'h0, afe_enable});
		// codes 10 and 11 both give ratio 64, the only one short enough
		w = 2 + $urandom % 2;
		apb(1, ba(`CSQ_CTRL_IDX), 32'(w) << 8, 0, 0);
		run_to(0, 20);
		chk("mux", {4'h0, d[27:0]}, {4'h0, mux_out});
		chk("pos code", {26'h0, d[13:8]}, {26'h0, pos_code});
		chk("neg code", {26'h0, d[5:0]}, {26'h0, neg_code});
		run_to(1, 31000);
		chk("ticks", 32'd192, tks);
		chk("stage clks", 1, 32'(cyc >= 30720 && cyc <= 30730));
		chk("stage", 0, {28'h0, active_stage});
		repeat (4) @(posedge sys_clk);
		chk("afe_enable", 1, {31'h0, afe_enable});
		chk("stage", 0, {28'h0, active_stage});
		// one tuning step on the positive code, then reread the result
		d = (d + 32'h100) & 32'h3F3F;
		apb(1, ba(`CSQ_OFS_BASE), d, 0, 0);
		apb(0, ba(`CSQ_OFS_BASE), 0, 0, d);
		repeat (2) @(posedge sys_clk);
		chk("pos step", {26'h0, d[13:8]}, {26'h0, pos_code});
		apb(0, ba(`CSQ_RES_BASE), 0, 0, 32'hFFFF);
		$display("test full power done");
		apb(1, ba(`CSQ_CTRL_IDX), 32'h1, 0, 0);
		repeat (3) @(posedge sys_clk);
		chk("afe_enable", 0, {31'h0, afe_enable});
		ones <= 1'b0;
		w = $urandom % 4;
		apb(1, ba(`CSQ_CTRL_IDX), 32'h302 | (32'(w) << 2), 0, 0);
		run_to(0, 20);
		run_to(1, 31000);
		run_to(0, 14000);
		chk("wake gap", 1, 32'(cyc >= 3200 * (w + 1) - 170 &&
			cyc <= 3200 * (w + 1) + 170));
		chk("wait ticks", 0, tks);
		apb(0, ba(`CSQ_RES_BASE), 0, 0, 32'h0);
		apb(1, ba(`CSQ_CTRL_IDX), 32'h1, 0, 0);
		$display("test low power done");
		test_done();
	end
endmodule : tb
